/* pkg/dadc_pkg.sv */
package dadc_pkg;

  // Result width and conversion latency in sample clocks.
  localparam int RES_W = 14;
  localparam int LATENCY = 5;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_RESULT_A = 8'h0C;
  localparam logic [7:0] OFF_RESULT_B = 8'h10;

  // Control register fields.
  localparam int CTRL_A_PD = 0;
  localparam int CTRL_A_OE_N = 1;
  localparam int CTRL_B_PD = 2;
  localparam int CTRL_B_OE_N = 3;
  localparam int CTRL_SWAP = 4;
  localparam int CTRL_ILV = 5;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h1A;

  // Interrupt status fields and reset values.
  localparam int IRQ_OVF_A = 0;
  localparam int IRQ_OVF_B = 1;
  localparam int IRQ_NEW_A = 2;
  localparam int IRQ_NEW_B = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // Result readback field: flag sits just above the code.
  localparam int RES_FLAG_BIT = 14;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Four-level format setting.
  typedef enum logic [1:0] {
    DADC_FMT_OB_STAB_OFF = 2'h0,
    DADC_FMT_OB_STAB_ON = 2'h1,
    DADC_FMT_TC_STAB_ON = 2'h2,
    DADC_FMT_TC_STAB_OFF = 2'h3
  } dadc_fmt_t;

  // Channel operating state.
  typedef enum logic [3:0] {
    DADC_ST_RUN_DRIVE = 4'h1,
    DADC_ST_RUN_HIZ = 4'h2,
    DADC_ST_NAP = 4'h4,
    DADC_ST_SLEEP = 4'h8
  } dadc_state_t;

endpackage

/* hw/dadc_top.sv */
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// [RL1] Each channel takes a sample on its own clock's rising edge.
// [RL2] Swap control high: channel A on bus A, channel B on bus B.
// [RL3] Swap control low: channel A on bus B, channel B on bus A.
// [RL4] Outside party ties swap and both clocks together to interleave one bus.
// [RL5] Power-down low, enable low: convert and drive the bus.
// [RL6] Power-down low, enable high: convert, outputs high impedance.
// [RL7] Power-down high, enable low: nap, outputs high impedance.
// [RL8] Power-down high, enable high: sleep, outputs high impedance.
// [RL9] Each channel's control pair affects only that channel.
// [RL10] Each bus carries fourteen bits, bit 13 most significant.
// [RL11] Overflow flag is high when the input went out of range.
// [RL12] One format setting governs both channels together.
// [RL13] Four format levels choose number format and stabilizer.
// [RL14] Result appears five sample clocks after the sample was taken.
// [RL15] Two's complement equals offset binary with the top bit inverted.
// [RL16] Overflow flag moves together with its own sample's data.
module dadc_top #(
  parameter int RES_W = dadc_pkg::RES_W,
  parameter int LATENCY = dadc_pkg::LATENCY
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite register slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sample clock pins.
  input wire logic chan_a_sample_clock,
  input wire logic chan_b_sample_clock,
  // Quantizer results from the converter cores.
  input wire logic [RES_W-1:0] chan_a_core_code,
  input wire logic chan_a_core_over,
  input wire logic [RES_W-1:0] chan_b_core_code,
  input wire logic chan_b_core_over,
  // Output buses; drive_n low while the bus is driven.
  output logic [RES_W-1:0] bus_a_result,
  output logic bus_a_range_flag,
  output logic bus_a_drive_n,
  output logic [RES_W-1:0] bus_b_result,
  output logic bus_b_range_flag,
  output logic bus_b_drive_n,
  // Stabilizer enable and interrupt.
  output logic stab_enable,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Channel state from its power-down and active-low enable.
  function automatic dadc_pkg::dadc_state_t chan_state(input logic pd, input logic oe_n);
    case ({pd, oe_n})
      2'h0: chan_state = dadc_pkg::DADC_ST_RUN_DRIVE; // [RL5]
      2'h1: chan_state = dadc_pkg::DADC_ST_RUN_HIZ; // [RL6]
      2'h2: chan_state = dadc_pkg::DADC_ST_NAP; // [RL7]
      default: chan_state = dadc_pkg::DADC_ST_SLEEP; // [RL8]
    endcase
  endfunction

  // Output coding: two's complement inverts the top bit.
  function automatic logic [RES_W-1:0] fmt_code(input logic [RES_W-1:0] c, input logic tc);
    fmt_code = {c[RES_W-1] ^ tc, c[RES_W-2:0]}; // [RL15]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode.

  logic [dadc_pkg::CTRL_W-1:0] ctrl;
  logic [dadc_pkg::IRQ_W-1:0] irq_status;
  logic [dadc_pkg::IRQ_W-1:0] irq_mask;
  logic [dadc_pkg::IRQ_W-1:0] irq_event;
  dadc_pkg::dadc_fmt_t fmt;
  dadc_pkg::dadc_state_t state [0:1];
  logic twos;
  logic running [0:1];
  logic driving [0:1];
  logic [1:0] clk_meta;
  logic [1:0] clk_sync;
  logic [1:0] clk_prev;
  logic [1:0] edge_hit;
  logic [RES_W:0] pipe [0:1][0:LATENCY-1];
  logic [RES_W:0] result [0:1];
  logic swap_eff;
  logic wr_go;
  logic rd_go;

  // One format setting serves both channels.
  assign fmt = dadc_pkg::dadc_fmt_t'(ctrl[dadc_pkg::CTRL_MODE_LO +: 2]); // [RL12]
  assign twos = (fmt == dadc_pkg::DADC_FMT_TC_STAB_ON) ||
                (fmt == dadc_pkg::DADC_FMT_TC_STAB_OFF); // [RL13]
  assign stab_enable = (fmt == dadc_pkg::DADC_FMT_OB_STAB_ON) ||
                       (fmt == dadc_pkg::DADC_FMT_TC_STAB_ON); // [RL13]

  // Each channel reads only its own control pair.
  assign state[0] = chan_state(ctrl[dadc_pkg::CTRL_A_PD], ctrl[dadc_pkg::CTRL_A_OE_N]); // [RL9]
  assign state[1] = chan_state(ctrl[dadc_pkg::CTRL_B_PD], ctrl[dadc_pkg::CTRL_B_OE_N]); // [RL9]
  assign running[0] = state[0] inside {dadc_pkg::DADC_ST_RUN_DRIVE, dadc_pkg::DADC_ST_RUN_HIZ};
  assign running[1] = state[1] inside {dadc_pkg::DADC_ST_RUN_DRIVE, dadc_pkg::DADC_ST_RUN_HIZ};
  assign driving[0] = state[0] == dadc_pkg::DADC_ST_RUN_DRIVE;
  assign driving[1] = state[1] == dadc_pkg::DADC_ST_RUN_DRIVE;

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock synchronisers and edge detect.

  // Two synchroniser flip-flops and one edge-detect flip-flop per pin; the first stage feeds no logic.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_meta <= 2'h0;
      clk_sync <= 2'h0;
      clk_prev <= 2'h0;
    end else begin
      clk_meta <= {chan_b_sample_clock, chan_a_sample_clock};
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  assign edge_hit = clk_sync & ~clk_prev; // [RL1]

  ////////////////////////////////////////////////////////////////////////////
  // Conversion pipelines, one per channel, stepped by its own clock.

  // Code and flag travel as one word so they stay aligned.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        for (int s = 0; s < LATENCY; s++) begin
          pipe[c][s] <= '0;
        end
        result[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (edge_hit[c] && running[c]) begin // [RL1]
          pipe[c][0] <= (c == 0) ? {chan_a_core_over, chan_a_core_code}
                                 : {chan_b_core_over, chan_b_core_code}; // [RL16]
          for (int s = 1; s < LATENCY; s++) begin
            pipe[c][s] <= pipe[c][s-1];
          end
          result[c] <= pipe[c][LATENCY-1]; // [RL14]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output bus routing.

  // Interleave mode follows channel A's clock level as the swap control.
  assign swap_eff = ctrl[dadc_pkg::CTRL_ILV] ? clk_sync[0] : ctrl[dadc_pkg::CTRL_SWAP]; // [RL4]

  // Buses are registered; swap high keeps channels straight, low crosses them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_a_result <= '0;
      bus_a_range_flag <= 1'b0;
      bus_a_drive_n <= 1'b1;
      bus_b_result <= '0;
      bus_b_range_flag <= 1'b0;
      bus_b_drive_n <= 1'b1;
    end else if (swap_eff) begin
      bus_a_result <= fmt_code(result[0][RES_W-1:0], twos); // [RL2] [RL10]
      bus_a_range_flag <= result[0][RES_W]; // [RL11]
      bus_a_drive_n <= ~driving[0]; // [RL2]
      bus_b_result <= fmt_code(result[1][RES_W-1:0], twos); // [RL2]
      bus_b_range_flag <= result[1][RES_W];
      bus_b_drive_n <= ~driving[1];
    end else begin
      bus_a_result <= fmt_code(result[1][RES_W-1:0], twos); // [RL3]
      bus_a_range_flag <= result[1][RES_W];
      bus_a_drive_n <= ~driving[1]; // [RL3]
      bus_b_result <= fmt_code(result[0][RES_W-1:0], twos); // [RL3]
      bus_b_range_flag <= result[0][RES_W];
      bus_b_drive_n <= ~driving[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  // Address and data are taken together when no response is pending.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
  assign rd_go = s_axi_arready;

  // Write response one cycle after the write is taken.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dadc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr inside {dadc_pkg::OFF_CTRL, dadc_pkg::OFF_IRQ_STATUS,
                      dadc_pkg::OFF_IRQ_MASK}) ? dadc_pkg::RESP_OKAY : dadc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and mask registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= dadc_pkg::CTRL_RESET;
      irq_mask <= dadc_pkg::IRQ_MASK_RESET;
    end else if (wr_go && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == dadc_pkg::OFF_CTRL) begin
        ctrl <= s_axi_wdata[dadc_pkg::CTRL_W-1:0];
      end
      if (s_axi_awaddr == dadc_pkg::OFF_IRQ_MASK) begin
        irq_mask <= s_axi_wdata[dadc_pkg::IRQ_W-1:0];
      end
    end
  end

  // Read data one cycle after the address is taken.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= dadc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dadc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dadc_pkg::OFF_CTRL: s_axi_rdata <= {24'h0, ctrl};
        dadc_pkg::OFF_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
        dadc_pkg::OFF_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask};
        dadc_pkg::OFF_RESULT_A: s_axi_rdata <= {17'h0, result[0]};
        dadc_pkg::OFF_RESULT_B: s_axi_rdata <= {17'h0, result[1]};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= dadc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  // Events: a new result per channel, and a new result carrying the flag.
  assign irq_event[dadc_pkg::IRQ_OVF_A] = edge_hit[0] && running[0] && pipe[0][LATENCY-1][RES_W];
  assign irq_event[dadc_pkg::IRQ_OVF_B] = edge_hit[1] && running[1] && pipe[1][LATENCY-1][RES_W];
  assign irq_event[dadc_pkg::IRQ_NEW_A] = edge_hit[0] && running[0];
  assign irq_event[dadc_pkg::IRQ_NEW_B] = edge_hit[1] && running[1];

  // Sticky status, write one to clear; a same-cycle event wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_status <= dadc_pkg::IRQ_STATUS_RESET;
    end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == dadc_pkg::OFF_IRQ_STATUS) begin
      irq_status <= (irq_status & ~s_axi_wdata[dadc_pkg::IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_swap_straight: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
    swap_eff |=> bus_a_result == fmt_code($past(result[0][RES_W-1:0]), $past(twos))
      && bus_a_range_flag == $past(result[0][RES_W]))
    else $error("bus A does not carry channel A while swap is high");
  a_swap_cross: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    !swap_eff |=> bus_b_result == fmt_code($past(result[0][RES_W-1:0]), $past(twos))
      && bus_b_range_flag == $past(result[0][RES_W]))
    else $error("bus B does not carry channel A while swap is low");
  a_drive_normal: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
    (swap_eff && !ctrl[dadc_pkg::CTRL_A_PD] && !ctrl[dadc_pkg::CTRL_A_OE_N])
      |=> !bus_a_drive_n)
    else $error("bus A not driven in normal operation");
  a_hiz_running: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    (swap_eff && !ctrl[dadc_pkg::CTRL_A_PD] && ctrl[dadc_pkg::CTRL_A_OE_N] && edge_hit[0])
      |=> bus_a_drive_n && result[0] == $past(pipe[0][LATENCY-1]))
    else $error("channel A must convert with outputs released");
  a_nap_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RL7] [RL9]
    (ctrl[dadc_pkg::CTRL_A_PD] && !ctrl[dadc_pkg::CTRL_A_OE_N] && !swap_eff)
      |=> bus_b_drive_n && $stable(result[0]))
    else $error("channel A in nap must halt and release its bus");
  a_sleep_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
    (ctrl[dadc_pkg::CTRL_B_PD] && ctrl[dadc_pkg::CTRL_B_OE_N] && swap_eff)
      |=> bus_b_drive_n && $stable(result[1]))
    else $error("channel B in sleep must halt and release its bus");
  a_fmt_levels: assert property (@(posedge clk_sys) disable iff (rst) // [RL12] [RL13]
    stab_enable == (ctrl[dadc_pkg::CTRL_MODE_LO+1] ^ ctrl[dadc_pkg::CTRL_MODE_LO])
      && twos == ctrl[dadc_pkg::CTRL_MODE_LO+1])
    else $error("format level decodes wrongly");
  a_twos_msb: assert property (@(posedge clk_sys) disable iff (rst) // [RL15] [RL10]
    (twos && swap_eff) |=> bus_a_result[RES_W-1] == !$past(result[0][RES_W-1]))
    else $error("two's complement top bit not inverted");
  a_latency_five: assert property (@(posedge clk_sys) disable iff (rst) // [RL14] [RL16] [RL11]
    (edge_hit[0] && running[0]) |=> result[0] == $past(pipe[0][LATENCY-1])
      && pipe[0][0] == $past({chan_a_core_over, chan_a_core_code}))
    else $error("channel A pipeline did not advance on its edge");
  a_sample_edge: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
    !edge_hit[1] |=> $stable(result[1]))
    else $error("channel B result moved without its clock edge");
  a_irq_sticky: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
    irq_event[dadc_pkg::IRQ_OVF_A] |=> irq_status[dadc_pkg::IRQ_OVF_A])
    else $error("overflow event lost");

  c_swap_change: cover property (@(posedge clk_sys) disable iff (rst) $changed(swap_eff));
  c_overflow: cover property (@(posedge clk_sys) disable iff (rst) bus_a_range_flag);
  c_nap_to_run: cover property (@(posedge clk_sys) disable iff (rst)
    $fell(ctrl[dadc_pkg::CTRL_A_PD]));
  c_irq: cover property (@(posedge clk_sys) disable iff (rst) irq);

endmodule

/* tb/dadc_far_end.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-side capture logic that makes the two sample clocks on request.
module dadc_far_end (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Requests from the bench.
  input wire logic fire_a,
  input wire logic fire_b,
  input wire logic tie_clocks,
  // Sample clock pins.
  output logic chan_a_sample_clock,
  output logic chan_b_sample_clock
);
  logic [3:0] cnt_a;
  logic [3:0] cnt_b;

  // Each request makes one pulse, four cycles high then four low.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_a <= 4'h0;
    end else if (cnt_a != 4'h0) begin
      cnt_a <= cnt_a - 4'h1;
    end else if (fire_a) begin
      cnt_a <= 4'h8;
    end
  end

  // Channel B clock is made the same way on its own requests.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_b <= 4'h0;
    end else if (cnt_b != 4'h0) begin
      cnt_b <= cnt_b - 4'h1;
    end else if (fire_b) begin
      cnt_b <= 4'h8;
    end
  end

  // Clocks stand low between pulses; tying shares clock A with B.
  assign chan_a_sample_clock = cnt_a > 4'h4;
  assign chan_b_sample_clock = tie_clocks ? chan_a_sample_clock : (cnt_b > 4'h4);
endmodule

/* tb/test_dual_adc_output_bus_control.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench with a queue model of both conversion pipelines.
module test_dual_adc_output_bus_control;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic chan_a_sample_clock, chan_b_sample_clock;
  logic [13:0] chan_a_core_code = 14'h0, chan_b_core_code = 14'h0;
  logic chan_a_core_over = 1'b0, chan_b_core_over = 1'b0;
  logic [13:0] bus_a_result, bus_b_result;
  logic bus_a_range_flag, bus_b_range_flag, bus_a_drive_n, bus_b_drive_n;
  logic stab_enable, irq;
  logic fire_a = 1'b0, fire_b = 1'b0;
  logic tie_clocks = 1'b0;
  logic [14:0] q_a[$], q_b[$];
  logic [14:0] cur_a = 15'h0, cur_b = 15'h0;
  logic [7:0] ctrl = dadc_pkg::CTRL_RESET;
  logic [1:0] resp;
  logic [31:0] rd;
  int fail_count = 0, total_checks = 0;

  dadc_top dut (
    .clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .chan_a_sample_clock(chan_a_sample_clock), .chan_b_sample_clock(chan_b_sample_clock),
    .chan_a_core_code(chan_a_core_code), .chan_a_core_over(chan_a_core_over),
    .chan_b_core_code(chan_b_core_code), .chan_b_core_over(chan_b_core_over),
    .bus_a_result(bus_a_result), .bus_a_range_flag(bus_a_range_flag),
    .bus_a_drive_n(bus_a_drive_n), .bus_b_result(bus_b_result),
    .bus_b_range_flag(bus_b_range_flag), .bus_b_drive_n(bus_b_drive_n),
    .stab_enable(stab_enable), .irq(irq));
  dadc_far_end far (.clk_sys(clk_sys), .rst(rst), .fire_a(fire_a), .fire_b(fire_b),
    .tie_clocks(tie_clocks), .chan_a_sample_clock(chan_a_sample_clock),
    .chan_b_sample_clock(chan_b_sample_clock));

  // Free-running 20 MHz system clock.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reports one comparison and counts it.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One register write; both channels offered together, response awaited.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One register read, then a comparison of data and response.
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    cmp(rd, e, "read data");
    cmp(s_axi_rresp, er, "read response");
  endtask

  // Model step: a captured sample leaves the pipe five samples later.
  task automatic adv(ref logic [14:0] q[$], ref logic [14:0] cur, input logic [14:0] s);
    q.push_back(s);
    if (q.size() > 5) cur = q.pop_front();
  endtask

  // One sample clock pulse per requested channel with fresh random codes.
  task automatic pulse(input logic fa, input logic fb);
    @(posedge clk_sys);
    chan_a_core_code <= 14'($urandom);
    chan_b_core_code <= 14'($urandom);
    chan_a_core_over <= ($urandom % 4) == 0;
    chan_b_core_over <= ($urandom % 4) == 0;
    fire_a <= fa;
    fire_b <= fb;
    @(posedge clk_sys);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    if (fa && !ctrl[0]) adv(q_a, cur_a, {chan_a_core_over, chan_a_core_code});
    if (fb && !ctrl[2]) adv(q_b, cur_b, {chan_b_core_over, chan_b_core_code});
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    if (ctrl[5]) chk_bus(1'b1); // Tied clock high: buses straight.
    repeat (8) @(posedge clk_sys);
  endtask

  // Compares both buses and the stabilizer against the model.
  // In interleave mode the swap follows the tied clock level, given as hi.
  task automatic chk_bus(input logic hi = 1'b0);
    logic [14:0] ra, rb;
    logic da, db, sw;
    sw = ctrl[5] ? hi : ctrl[4];
    ra = sw ? cur_a : cur_b;
    rb = sw ? cur_b : cur_a;
    da = sw ? (ctrl[0] | ctrl[1]) : (ctrl[2] | ctrl[3]);
    db = sw ? (ctrl[2] | ctrl[3]) : (ctrl[0] | ctrl[1]);
    ra[13] = ra[13] ^ ctrl[7];
    rb[13] = rb[13] ^ ctrl[7];
    cmp(bus_a_drive_n, da, "bus a drive");
    cmp(bus_b_drive_n, db, "bus b drive");
    if (!da) cmp({bus_a_range_flag, bus_a_result}, ra, "bus a word");
    if (!db) cmp({bus_b_range_flag, bus_b_result}, rb, "bus b word");
    cmp(stab_enable, ctrl[7] ^ ctrl[6], "stabilizer");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    test_done;
  end

  // Main sequence of tests.
  initial begin
    void'($urandom(32'h8349));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk_bus; // Buses released after reset.
    chk_reg(dadc_pkg::OFF_CTRL, 32'(dadc_pkg::CTRL_RESET), dadc_pkg::RESP_OKAY);
    chk_reg(dadc_pkg::OFF_IRQ_MASK, 32'h0, dadc_pkg::RESP_OKAY);
    chk_reg(8'h14, 32'h0, dadc_pkg::RESP_SLVERR);
    wr(dadc_pkg::OFF_RESULT_A, 32'h7FFF);
    cmp(resp, dadc_pkg::RESP_SLVERR, "result write response");
    $display("test registers done");
    // Every format level with both routings, pipeline filled each time.
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        ctrl = {2'(m), 1'b0, 1'(s), 4'h0};
        wr(dadc_pkg::OFF_CTRL, {24'h0, ctrl});
        repeat (6) begin
          pulse(1'b1, 1'b1);
          chk_bus; // Routing, format, latency and flag.
        end
        chk_reg(dadc_pkg::OFF_RESULT_A, {17'h0, cur_a}, dadc_pkg::RESP_OKAY); // Raw code.
      end
    end
    $display("test formats done");
    // Every power-down and drive pairing of both channels.
    for (int i = 0; i < 16; i++) begin
      ctrl = {3'h0, 1'($urandom), 4'(i)};
      wr(dadc_pkg::OFF_CTRL, {24'h0, ctrl});
      pulse(1'b1, 1'b1);
      chk_bus; // Drive and freeze per channel.
    end
    $display("test modes done");
    // Both clocks tied to channel A: the buses alternate with the clock level.
    tie_clocks <= 1'b1;
    ctrl = 8'h20;
    wr(dadc_pkg::OFF_CTRL, 32'h20);
    repeat (6) begin
      pulse(1'b1, 1'b1);
      chk_bus; // Tied clock low: buses crossed.
    end
    tie_clocks <= 1'b0;
    $display("test interleave done");
    // Interrupt raised while masked, unmasked, then cleared.
    ctrl = 8'h10;
    wr(dadc_pkg::OFF_CTRL, 32'h10);
    wr(dadc_pkg::OFF_IRQ_MASK, 32'h0);
    wr(dadc_pkg::OFF_IRQ_STATUS, 32'hF);
    pulse(1'b1, 1'b0);
    chk_bus; // Only channel A moves.
    chk_reg(dadc_pkg::OFF_IRQ_STATUS, 32'h4 | 32'(cur_a[14]), dadc_pkg::RESP_OKAY);
    cmp(rd & 32'hC, 32'h4, "new result status");
    cmp(irq, 1'b0, "masked interrupt");
    wr(dadc_pkg::OFF_IRQ_MASK, 32'h4);
    cmp(irq, 1'b1, "unmasked interrupt");
    wr(dadc_pkg::OFF_IRQ_STATUS, 32'h4);
    cmp(irq, 1'b0, "cleared interrupt");
    $display("test interrupt done");
    test_done;
  end
endmodule
